// [hdl/dual_port_io_and_dac_load.sv]
// Chosen here: the address map and register access over APB.
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// [RULE_01] two byte ports, direction set per port
// [RULE_02] only first two interface ports exist
// [RULE_03] reset leaves both ports as inputs
// [RULE_04] input port undriven, output drives latch
// [RULE_05] low power stops port accesses
// [RULE_06] host reloads analog setup after low power
// [RULE_07] two channels hold 12-bit codes
// [RULE_08] each channel has own range select
// [RULE_09] host picks unipolar for current output
// [RULE_10] decode address into selects and strobes
// [RULE_11] read data driven only on reads
module dual_port_io_and_dac_load (
  input wire logic clock,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [dio_dac_pkg::ADDR_W-1:0] paddr,
  input wire logic [dio_dac_pkg::DATA_W-1:0] pwdata,
  output logic [dio_dac_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [dio_dac_pkg::PORT_W-1:0] firstPortIn,
  output logic [dio_dac_pkg::PORT_W-1:0] firstPortOut,
  output logic [dio_dac_pkg::PORT_W-1:0] firstPortOe,
  input wire logic [dio_dac_pkg::PORT_W-1:0] secondPortIn,
  output logic [dio_dac_pkg::PORT_W-1:0] secondPortOut,
  output logic [dio_dac_pkg::PORT_W-1:0] secondPortOe,
  output logic [dio_dac_pkg::DAC_W-1:0] dac0Code,
  output logic dac0Bipolar,
  output logic [dio_dac_pkg::DAC_W-1:0] dac1Code,
  output logic dac1Bipolar,
  output logic lowPower
);
  import dio_dac_pkg::*;

  // bus decode
  regSel_t sel;
  logic setup;
  logic access;
  logic blocked;
  logic badAccess;
  logic wrStrobe;
  logic rdStrobe;

  // register state
  logic firstOe_reg, firstOe_next;
  logic secondOe_reg, secondOe_next;
  logic lowPower_reg, lowPower_next;
  logic [PORT_W-1:0] firstOut_reg, firstOut_next;
  logic [PORT_W-1:0] secondOut_reg, secondOut_next;
  logic [DAC_W-1:0] dac0Code_reg, dac0Code_next;
  logic [DAC_W-1:0] dac1Code_reg, dac1Code_next;
  logic dac0Bip_reg, dac0Bip_next;
  logic dac1Bip_reg, dac1Bip_next;
  logic [DATA_W-1:0] rdata_reg, rdata_next;
  logic err_reg, err_next;

  // pin synchroniser and agreement filter
  logic [PIN_W-1:0] pinS1_reg, pinS1_next;
  logic [PIN_W-1:0] pinS2_reg, pinS2_next;
  logic [PIN_W-1:0] pinS3_reg, pinS3_next;
  logic [PIN_W-1:0] pinVal_reg, pinVal_next;
  logic [PIN_W-1:0] agree;

  // only the first two ports of the peripheral interface are built; the third
  // has no pins and no register here [RULE_02]
  always_comb begin
    sel = decodeSel(paddr); // [RULE_10]
    setup = psel && !penable;
    access = psel && penable;
    // in low power only the control word stays reachable [RULE_05]
    blocked = lowPower_reg && (sel != SEL_CTRL);
    badAccess = (sel == SEL_NONE) || blocked;
    wrStrobe = access && pwrite && !badAccess; // [RULE_10]
    rdStrobe = setup && !pwrite && !badAccess; // [RULE_10]
  end

  // zero wait states: every access phase completes at once
  assign pready = access;
  assign pslverr = err_reg;
  assign prdata = rdata_reg;

  always_comb begin
    firstOe_next = firstOe_reg;
    secondOe_next = secondOe_reg;
    lowPower_next = lowPower_reg;
    firstOut_next = firstOut_reg;
    secondOut_next = secondOut_reg;
    dac0Code_next = dac0Code_reg;
    dac1Code_next = dac1Code_reg;
    dac0Bip_next = dac0Bip_reg;
    dac1Bip_next = dac1Bip_reg;
    if (wrStrobe) begin
      unique case (sel)
        SEL_CTRL: begin
          firstOe_next = pwdata[CTRL_FIRST_OUT_BIT]; // [RULE_01]
          secondOe_next = pwdata[CTRL_SECOND_OUT_BIT]; // [RULE_01]
          lowPower_next = pwdata[CTRL_LOW_POWER_BIT];
        end
        SEL_FIRST: firstOut_next = pwdata[PORT_W-1:0];
        SEL_SECOND: secondOut_next = pwdata[PORT_W-1:0];
        SEL_DAC0: begin
          dac0Code_next = pwdata[DAC_CODE_LSB +: DAC_W]; // [RULE_07]
          dac0Bip_next = pwdata[DAC_RANGE_BIT]; // [RULE_08]
        end
        SEL_DAC1: begin
          dac1Code_next = pwdata[DAC_CODE_LSB +: DAC_W]; // [RULE_07]
          dac1Bip_next = pwdata[DAC_RANGE_BIT]; // [RULE_08]
        end
        SEL_NONE: begin
        end
      endcase
    end
    // analog setup is lost in low power, so the host must reload it [RULE_06]
    if (lowPower_reg) begin
      dac0Code_next = DAC_RST;
      dac1Code_next = DAC_RST;
      dac0Bip_next = 1'b0;
      dac1Bip_next = 1'b0;
    end
  end

  // read data is loaded at setup and cleared otherwise, so it is nonzero
  // only in the access phase of a read to this block [RULE_11]
  always_comb begin
    rdata_next = DATA_ZERO;
    err_next = 1'b0;
    if (setup) begin
      err_next = badAccess;
    end
    if (rdStrobe) begin
      unique case (sel)
        SEL_CTRL: begin
          rdata_next[CTRL_FIRST_OUT_BIT] = firstOe_reg;
          rdata_next[CTRL_SECOND_OUT_BIT] = secondOe_reg;
          rdata_next[CTRL_LOW_POWER_BIT] = lowPower_reg;
        end
        SEL_FIRST: rdata_next[PORT_W-1:0] = pinVal_reg[PORT_W-1:0];
        SEL_SECOND: rdata_next[PORT_W-1:0] = pinVal_reg[PIN_W-1:PORT_W];
        SEL_DAC0: begin
          rdata_next[DAC_CODE_LSB +: DAC_W] = dac0Code_reg;
          rdata_next[DAC_RANGE_BIT] = dac0Bip_reg;
        end
        SEL_DAC1: begin
          rdata_next[DAC_CODE_LSB +: DAC_W] = dac1Code_reg;
          rdata_next[DAC_RANGE_BIT] = dac1Bip_reg;
        end
        SEL_NONE: begin
        end
      endcase
    end
  end

  // a pin change is taken only once the second and third stages agree,
  // which costs a cycle but rejects a one-sample glitch
  always_comb begin
    pinS1_next = {secondPortIn, firstPortIn};
    pinS2_next = pinS1_reg;
    pinS3_next = pinS2_reg;
    agree = pinS2_reg ~^ pinS3_reg;
    pinVal_next = (pinS3_reg & agree) | (pinVal_reg & ~agree);
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      firstOe_reg <= 1'b0; // [RULE_03]
      secondOe_reg <= 1'b0; // [RULE_03]
      lowPower_reg <= 1'b0;
      firstOut_reg <= PORT_RST;
      secondOut_reg <= PORT_RST;
      dac0Code_reg <= DAC_RST;
      dac1Code_reg <= DAC_RST;
      dac0Bip_reg <= 1'b0;
      dac1Bip_reg <= 1'b0;
      rdata_reg <= DATA_ZERO;
      err_reg <= 1'b0;
      pinS1_reg <= PIN_RST;
      pinS2_reg <= PIN_RST;
      pinS3_reg <= PIN_RST;
      pinVal_reg <= PIN_RST;
    end else begin
      firstOe_reg <= firstOe_next;
      secondOe_reg <= secondOe_next;
      lowPower_reg <= lowPower_next;
      firstOut_reg <= firstOut_next;
      secondOut_reg <= secondOut_next;
      dac0Code_reg <= dac0Code_next;
      dac1Code_reg <= dac1Code_next;
      dac0Bip_reg <= dac0Bip_next;
      dac1Bip_reg <= dac1Bip_next;
      rdata_reg <= rdata_next;
      err_reg <= err_next;
      pinS1_reg <= pinS1_next;
      pinS2_reg <= pinS2_next;
      pinS3_reg <= pinS3_next;
      pinVal_reg <= pinVal_next;
    end
  end

  // whole-port enables; low power releases every line [RULE_04] [RULE_05]
  assign firstPortOe = (firstOe_reg && !lowPower_reg) ? OE_ON : OE_OFF;
  assign secondPortOe = (secondOe_reg && !lowPower_reg) ? OE_ON : OE_OFF;
  assign firstPortOut = firstOut_reg; // [RULE_04]
  assign secondPortOut = secondOut_reg; // [RULE_04]
  // the range bit only picks the span; current output needs unipolar [RULE_09]
  assign dac0Code = dac0Code_reg;
  assign dac0Bipolar = dac0Bip_reg;
  assign dac1Code = dac1Code_reg;
  assign dac1Bipolar = dac1Bip_reg;
  assign lowPower = lowPower_reg;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  property p_wholePort;
    (firstPortOe == OE_ON || firstPortOe == OE_OFF) &&
    (secondPortOe == OE_ON || secondPortOe == OE_OFF);
  endproperty
  a_wholePort: assert property (p_wholePort) // [RULE_01]
    else $error("port enable not uniform across the byte");

  property p_resetInputs;
    $past(!rstn) |-> firstPortOe == OE_OFF && secondPortOe == OE_OFF;
  endproperty
  a_resetInputs: assert property (p_resetInputs) // [RULE_03]
    else $error("port driven right after reset");

  property p_driveLatch;
    psel && penable && pwrite && paddr == OFS_CTRL && !lowPower_reg &&
    pwdata[CTRL_FIRST_OUT_BIT] && !pwdata[CTRL_LOW_POWER_BIT]
    |=> firstPortOe == OE_ON && firstPortOut == $past(firstOut_reg);
  endproperty
  a_driveLatch: assert property (p_driveLatch) // [RULE_04]
    else $error("output port not driving its latch");

  property p_firstLatchLoad;
    psel && penable && pwrite && paddr == OFS_FIRST && !lowPower_reg
    |=> firstPortOut == $past(pwdata[PORT_W-1:0]);
  endproperty
  a_firstLatchLoad: assert property (p_firstLatchLoad) // [RULE_04]
    else $error("first port latch not loaded");

  property p_secondLatchLoad;
    psel && penable && pwrite && paddr == OFS_SECOND && !lowPower_reg
    |=> secondPortOut == $past(pwdata[PORT_W-1:0]);
  endproperty
  a_secondLatchLoad: assert property (p_secondLatchLoad) // [RULE_04]
    else $error("second port latch not loaded");

  property p_lowPowerIdle;
    lowPower_reg |-> firstPortOe == OE_OFF && secondPortOe == OE_OFF;
  endproperty
  a_lowPowerIdle: assert property (p_lowPowerIdle) // [RULE_05]
    else $error("port driven in low power");

  property p_lowPowerRefuse;
    psel && !penable && lowPower_reg && paddr == OFS_FIRST
    |=> pslverr ##1 firstOut_reg == $past(firstOut_reg);
  endproperty
  a_lowPowerRefuse: assert property (p_lowPowerRefuse) // [RULE_05]
    else $error("port access accepted in low power");

  property p_dacLoad;
    psel && penable && pwrite && paddr == OFS_DAC0 && !lowPower_reg
    |=> dac0Code == $past(pwdata[DAC_W-1:0]) && dac1Code == $past(dac1Code);
  endproperty
  a_dacLoad: assert property (p_dacLoad) // [RULE_07]
    else $error("channel code not loaded");

  property p_rangeSeparate;
    psel && penable && pwrite && paddr == OFS_DAC1 && !lowPower_reg
    |=> dac1Bipolar == $past(pwdata[DAC_RANGE_BIT]) &&
        dac0Bipolar == $past(dac0Bipolar);
  endproperty
  a_rangeSeparate: assert property (p_rangeSeparate) // [RULE_08]
    else $error("range select wrong or shared");

  property p_lostAfterLowPower;
    lowPower_reg ##1 lowPower_reg |-> dac0Code == DAC_RST && dac1Code == DAC_RST;
  endproperty
  a_lostAfterLowPower: assert property (p_lostAfterLowPower) // [RULE_06]
    else $error("analog setup kept through low power");

  property p_unmapped;
    psel && !penable && decodeSel(paddr) == SEL_NONE ##1 psel && penable
    |-> pready && pslverr && prdata == DATA_ZERO;
  endproperty
  a_unmapped: assert property (p_unmapped) // [RULE_10]
    else $error("unmapped address not refused");

  property p_readOnlyDrive;
    prdata != DATA_ZERO |-> psel && penable && !pwrite;
  endproperty
  a_readOnlyDrive: assert property (p_readOnlyDrive) // [RULE_11]
    else $error("read data driven outside a read");

  // read data and error stand for the access cycle only
  property p_readClears;
    psel && penable |=> prdata == DATA_ZERO && !pslverr;
  endproperty
  a_readClears: assert property (p_readClears) // [RULE_11]
    else $error("read data or error held past the access");

  property p_pinFilter;
    pinS2_reg == pinS3_reg |=> pinVal_reg == $past(pinS3_reg);
  endproperty
  a_pinFilter: assert property (p_pinFilter) // [RULE_04]
    else $error("agreed pin level not taken");
endmodule : dual_port_io_and_dac_load
`default_nettype wire

// [hdl/dio_dac_pkg.sv]
package dio_dac_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int PORT_W = 8;
  localparam int DAC_W = 12;
  localparam int PIN_W = 2 * PORT_W;
  localparam int SYNC_STAGES = 3;

  // register byte offsets, one aligned word each
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_FIRST = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_SECOND = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_DAC0 = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_DAC1 = 8'h10;

  // control register fields
  localparam int CTRL_FIRST_OUT_BIT = 0;
  localparam int CTRL_SECOND_OUT_BIT = 1;
  localparam int CTRL_LOW_POWER_BIT = 2;
  // analog channel register fields
  localparam int DAC_CODE_LSB = 0;
  localparam int DAC_RANGE_BIT = 16;

  localparam logic [PORT_W-1:0] PORT_RST = 8'h00;
  localparam logic [PORT_W-1:0] OE_ON = 8'hFF;
  localparam logic [PORT_W-1:0] OE_OFF = 8'h00;
  localparam logic [PIN_W-1:0] PIN_RST = 16'hFFFF;
  localparam logic [DAC_W-1:0] DAC_RST = 12'h000;
  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_CTRL,
    SEL_FIRST,
    SEL_SECOND,
    SEL_DAC0,
    SEL_DAC1
  } regSel_t;

  function automatic regSel_t decodeSel(input logic [ADDR_W-1:0] addr);
    regSel_t sel;
    sel = SEL_NONE;
    unique case (addr)
      OFS_CTRL: sel = SEL_CTRL;
      OFS_FIRST: sel = SEL_FIRST;
      OFS_SECOND: sel = SEL_SECOND;
      OFS_DAC0: sel = SEL_DAC0;
      OFS_DAC1: sel = SEL_DAC1;
      default: sel = SEL_NONE;
    endcase
    return sel;
  endfunction : decodeSel
endpackage : dio_dac_pkg

// [verification/pin_world.sv]
`timescale 1ns/10ps
`default_nettype none
// level seen on one byte of lines: the port drives, else an outside source, else the pull-ups
module pin_world (
  input wire logic [7:0] oe,
  input wire logic [7:0] out,
  input wire logic [7:0] extEn,
  input wire logic [7:0] extVal,
  output logic [7:0] pin
);
  assign pin = (oe & out) | (~oe & extEn & extVal) | (~oe & ~extEn);
endmodule : pin_world
`default_nettype wire

// [verification/tb.sv]
`timescale 1ns/10ps
`default_nettype none
module tb;
  import dio_dac_pkg::*;
  logic clock = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, errS, rdyS;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0, prdata, rdS;
  logic pready, pslverr, dac0Bipolar, dac1Bipolar, lowPower;
  logic [7:0] fIn, fOut, fOe, sIn, sOut, sOe, sExtEn = '0, sExtVal = '0;
  logic [DAC_W-1:0] dac0Code, dac1Code;
  int nErrors = 0, checkCount = 0;

  always #20 clock = ~clock;
  // mid-cycle copy gives the values that stood just before the next rising edge
  always @(negedge clock) begin
    rdS = prdata;
    errS = pslverr;
    rdyS = pready;
  end

  dual_port_io_and_dac_load uut (.clock(clock), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .firstPortIn(fIn), .firstPortOut(fOut), .firstPortOe(fOe),
    .secondPortIn(sIn), .secondPortOut(sOut), .secondPortOe(sOe), .dac0Code(dac0Code),
    .dac0Bipolar(dac0Bipolar), .dac1Code(dac1Code), .dac1Bipolar(dac1Bipolar),
    .lowPower(lowPower));
  pin_world firstLines (.oe(fOe), .out(fOut), .extEn(8'h00), .extVal(8'h00), .pin(fIn));
  pin_world secondLines (.oe(sOe), .out(sOut), .extEn(sExtEn), .extVal(sExtVal), .pin(sIn));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp) begin
      nErrors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                     input logic eErr, input logic [DATA_W-1:0] eRd);
    @(posedge clock);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1;
    // no wait-state count is assumed; the wait ends once the sampled pready is high, else only the watchdog ends it
    do begin
      @(posedge clock);
    end while (rdyS !== 1'b1);
    chk({31'h0, errS}, {31'h0, eErr});
    if (!w) chk(rdS, eRd);
    psel <= 0;
    penable <= 0;
    @(negedge clock);
    chk(prdata, DATA_ZERO);
  endtask : apb

  task automatic t_reset;
    chk(32'({fOe, sOe, fOut, sOut}), 0);
    apb(0, OFS_CTRL, 0, 0, 0);
    apb(0, OFS_FIRST, 0, 0, 32'h0000_00FF);
    apb(0, OFS_SECOND, 0, 0, 32'h0000_00FF);
    $display("test reset done");
  endtask : t_reset

  task automatic t_ports;
    @(posedge clock);
    sExtEn <= 8'hFF;
    sExtVal <= 8'h3C;
    apb(1, OFS_CTRL, 32'h0000_0001, 0, 0);
    apb(1, OFS_FIRST, 32'hFFFF_FFA5, 0, 0);
    chk(32'({fOe, fOut, sOe}), 32'h00FF_A500);
    repeat (5) @(posedge clock);
    apb(0, OFS_FIRST, 0, 0, 32'h0000_00A5);
    apb(0, OFS_SECOND, 0, 0, 32'h0000_003C);
    @(posedge clock);
    sExtEn <= 8'h00;
    apb(1, OFS_CTRL, 32'h0000_0002, 0, 0);
    apb(1, OFS_SECOND, 32'h0000_005A, 0, 0);
    chk(32'({fOe, fOut, sOe, sOut}), 32'h00A5_FF5A);
    repeat (5) @(posedge clock);
    apb(0, OFS_SECOND, 0, 0, 32'h0000_005A);
    apb(0, OFS_FIRST, 0, 0, 32'h0000_00FF);
    $display("test ports done");
  endtask : t_ports

  task automatic t_dac;
    apb(1, OFS_DAC0, 32'hFFFF_1ABC, 0, 0);
    // unipolar on channel 1 so its current sink is usable
    apb(1, OFS_DAC1, 32'h0000_0FFF, 0, 0);
    chk(32'({dac0Code, dac0Bipolar, dac1Code, dac1Bipolar}), 32'h02AF_3FFE);
    apb(0, OFS_DAC0, 0, 0, 32'h0001_0ABC);
    apb(0, OFS_DAC1, 0, 0, 32'h0000_0FFF);
    $display("test dac done");
  endtask : t_dac

  task automatic t_decode;
    apb(0, 8'h14, 0, 1, 0);
    apb(1, 8'h02, 32'h0000_0005, 1, 0);
    apb(0, OFS_CTRL, 0, 0, 32'h0000_0002);
    $display("test decode done");
  endtask : t_decode

  task automatic t_lowpower;
    apb(1, OFS_CTRL, 32'h0000_0006, 0, 0);
    // codes are cleared on the first edge that sees low power set
    @(negedge clock);
    chk(32'({fOe, sOe, lowPower}), 32'h0000_0001);
    chk(32'({dac0Code, dac1Code}), 32'h0000_0000);
    apb(1, OFS_DAC0, 32'h0000_0123, 1, 0);
    apb(0, OFS_FIRST, 0, 1, 0);
    apb(1, OFS_CTRL, 32'h0000_0002, 0, 0);
    chk(32'({sOe, sOut, dac0Code}), 32'h0FF5_A000);
    apb(1, OFS_DAC0, 32'h0000_0123, 0, 0);
    apb(0, OFS_DAC0, 0, 0, 32'h0000_0123);
    $display("test lowpower done");
  endtask : t_lowpower

  task automatic end_sim;
    $display("checks %0d errors %0d", checkCount, nErrors);
    if (nErrors == 0 && checkCount > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_sim

  initial begin
    repeat (5) @(posedge clock);
    rstn <= 1;
    t_reset();
    t_ports();
    t_dac();
    t_decode();
    t_lowpower();
    end_sim();
  end

  // the whole sequence needs under a hundred cycles
  initial begin
    repeat (3000) @(posedge clock);
    nErrors++;
    end_sim();
  end
endmodule : tb
`default_nettype wire
